// [pkg/swk_defines.svh]
// Offsets, field positions and reset values of the standby wake source block.
`ifndef SWK_DEFINES_SVH
`define SWK_DEFINES_SVH
`define SWK_NSRC 4
`define SWK_ADDR_W 8
`define SWK_OFS_MODE 8'h00
`define SWK_OFS_CLEAR 8'h04
`define SWK_OFS_STATUS 8'h08
`define SWK_SRC_STRIDE 8
`define SWK_SEL_LSB 4
`define SWK_SEEN_LSB 2
`define SWK_EN_BIT 0
`define SWK_SEL_RST 3'h2
`define SWK_SEEN_RST 2'h0
`define SWK_EN_RST 1'h0
`define SWK_RESP_OKAY 2'h0
`define SWK_RESP_SLVERR 2'h2
`endif

// [pkg/swk_pkg.sv]
// Types shared by the standby wake source modules.
package swk_pkg;
  typedef enum logic [2:0] {
    SWK_TRIG_LOW  = 3'h0,
    SWK_TRIG_HIGH = 3'h1,
    SWK_TRIG_FALL = 3'h2,
    SWK_TRIG_RISE = 3'h3,
    SWK_TRIG_BOTH = 3'h4
  } swk_trig_t;
  typedef logic [1:0] swk_seen_t;
endpackage : swk_pkg

// [pkg/swk_det_if.sv]
// Connection between the register slave and the wake detectors.
`timescale 1ns/1ps
interface swk_det_if;
  logic [3:0][2:0] sel;
  logic [3:0] en;
  logic [3:0] clr;
  logic [3:0] req;
  logic [3:0][1:0] seen;
  modport ctl (output sel, output en, output clr, input req, input seen);
  modport det (input sel, input en, input clr, output req, output seen);
endinterface : swk_det_if

// [rtl/swk_detect.sv]
// Pin synchronisers and level or edge wake detectors for the four sources.
`timescale 1ns/1ps
`include "swk_defines.svh"
module swk_detect
  import swk_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [3:0] pin,
  swk_det_if.det dif
);
  logic [3:0] s1_q, s1_d, s2_q, s2_d, s3_q, s3_d;
  logic [3:0] req_q, req_d;
  logic [3:0][1:0] seen_q, seen_d;

  // Decides whether one synchronised pin meets its selected condition; reserved codes never fire.
  function automatic logic trig_hit(input logic [2:0] sel, input logic lvl, input logic prev);
    case (sel)
      SWK_TRIG_LOW: trig_hit = !lvl;
      SWK_TRIG_HIGH: trig_hit = lvl;
      SWK_TRIG_FALL: trig_hit = prev && !lvl;
      SWK_TRIG_RISE: trig_hit = !prev && lvl;
      SWK_TRIG_BOTH: trig_hit = prev != lvl;
      default: trig_hit = 1'b0;
    endcase
  endfunction : trig_hit

  // Next values; a detection in the clear cycle wins so no wake event is lost.
  always_comb begin
    s1_d = pin;
    s2_d = s1_q;
    s3_d = s2_q;
    for (int i = 0; i < `SWK_NSRC; i++) begin
      req_d[i] = (dif.en[i] && trig_hit(dif.sel[i], s2_q[i], s3_q[i])) || (req_q[i] && !dif.clr[i]);
      seen_d[i] = dif.clr[i] ? `SWK_SEEN_RST : seen_q[i];
      if (dif.en[i] && dif.sel[i] == SWK_TRIG_BOTH) begin
        seen_d[i] = seen_d[i] | {s3_q[i] && !s2_q[i], !s3_q[i] && s2_q[i]};
      end
    end
  end

  // Registers; the first stage only feeds the second, edges come from stages two and three.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= 4'h0;
      s2_q <= 4'h0;
      s3_q <= 4'h0;
      req_q <= 4'h0;
      seen_q <= '0;
    end else if (ce) begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      req_q <= req_d;
      seen_q <= seen_d;
    end
  end

  assign dif.req = req_q;
  assign dif.seen = seen_q;
endmodule : swk_detect

// [rtl/swk_top.sv]
// AXI4-Lite register slave for the standby wake source configuration.
//
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "swk_defines.svh"
// Summary of operation
// - Selector codes: 000 low, 001 high, 010 fall, 011 rise, 100 both edges.
// - Read-only seen-edge field: 01 rise, 10 fall, 11 both, 00 none.
// - Per-source enable bit gates new detections, not a pending request; source 3 at bit 24.
// - Source 2 selector 22-20, seen 19-18, enable 16; source 3 selector 30-28.
// - Sources 1 and 0 repeat the layout in the low half-word.
// - Seen-edge valid only in both-edges mode; cleared with the request clear.
module swk_top
  import swk_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic CLK_EN,
  input wire logic [3:0] EXT_INT,
  output logic [3:0] WAKE_REQ,
  input wire logic [`SWK_ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [`SWK_ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  swk_det_if dif ();

  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [`SWK_ADDR_W-1:0] aw_addr_q, aw_addr_d;
  logic [31:0] w_data_q, w_data_d;
  logic [3:0] w_strb_q, w_strb_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic [3:0][2:0] sel_q, sel_d;
  logic [3:0] en_q, en_d, clr_d;
  logic [31:0] mode_word, wr_word;
  logic do_write;

  // True when the word address names one of the three registers.
  function automatic logic addr_hit(input logic [`SWK_ADDR_W-1:0] a);
    addr_hit = a == `SWK_OFS_MODE || a == `SWK_OFS_CLEAR || a == `SWK_OFS_STATUS;
  endfunction : addr_hit

  // Applies byte strobes to an old word, used for the mode register only.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    for (int b = 0; b < 4; b++) begin
      merge[b*8 +: 8] = strb[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction : merge

  // Assembles the mode register; reserved and undefined bits read as zero.
  always_comb begin
    mode_word = 32'h0;
    for (int i = 0; i < `SWK_NSRC; i++) begin
      mode_word[i*`SWK_SRC_STRIDE + `SWK_SEL_LSB +: 3] = sel_q[i];
      mode_word[i*`SWK_SRC_STRIDE + `SWK_SEEN_LSB +: 2] = dif.seen[i];
      mode_word[i*`SWK_SRC_STRIDE + `SWK_EN_BIT] = en_q[i];
    end
  end

  // Handshake readies; everything stalls while the clock enable is low.
  assign S_AXI_AWREADY = CLK_EN && !aw_have_q && !bvalid_q;
  assign S_AXI_WREADY = CLK_EN && !w_have_q && !bvalid_q;
  assign S_AXI_ARREADY = CLK_EN && !rvalid_q;
  assign do_write = aw_have_q && w_have_q && !bvalid_q;
  assign wr_word = merge(mode_word, w_data_q, w_strb_q);

  // Write channel next values: address and data are taken in either order.
  always_comb begin
    aw_have_d = aw_have_q;
    aw_addr_d = aw_addr_q;
    w_have_d = w_have_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_have_d = 1'b1;
      aw_addr_d = {S_AXI_AWADDR[`SWK_ADDR_W-1:2], 2'h0};
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_have_d = 1'b1;
      w_data_d = S_AXI_WDATA;
      w_strb_d = S_AXI_WSTRB;
    end
    if (do_write) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = (addr_hit(aw_addr_q) && aw_addr_q != `SWK_OFS_STATUS) ? `SWK_RESP_OKAY : `SWK_RESP_SLVERR;
    end else if (bvalid_q && S_AXI_BREADY) begin
      bvalid_d = 1'b0;
    end
  end

  // Register next values; the clear register is write-one pulses and stores nothing.
  always_comb begin
    sel_d = sel_q;
    en_d = en_q;
    clr_d = 4'h0;
    if (do_write && aw_addr_q == `SWK_OFS_MODE) begin
      for (int i = 0; i < `SWK_NSRC; i++) begin
        // Selector and enable are taken as written; ordering them is left to software.
        sel_d[i] = wr_word[i*`SWK_SRC_STRIDE + `SWK_SEL_LSB +: 3];
        en_d[i] = wr_word[i*`SWK_SRC_STRIDE + `SWK_EN_BIT];
      end
    end
    if (do_write && aw_addr_q == `SWK_OFS_CLEAR && w_strb_q[0]) begin
      clr_d = w_data_q[3:0];
    end
  end

  // Read channel next values; unmapped reads answer zero with a slave error.
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid_d = 1'b1;
      rresp_d = addr_hit({S_AXI_ARADDR[`SWK_ADDR_W-1:2], 2'h0}) ? `SWK_RESP_OKAY : `SWK_RESP_SLVERR;
      case ({S_AXI_ARADDR[`SWK_ADDR_W-1:2], 2'h0})
        `SWK_OFS_MODE: rdata_d = mode_word;
        `SWK_OFS_STATUS: rdata_d = {28'h0, dif.req};
        default: rdata_d = 32'h0;
      endcase
    end else if (rvalid_q && S_AXI_RREADY) begin
      rvalid_d = 1'b0;
    end
  end

  // All slave state registers; the clear pulse lasts one enabled cycle.
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
      w_have_q <= 1'b0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `SWK_RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= `SWK_RESP_OKAY;
      sel_q <= {4{`SWK_SEL_RST}};
      en_q <= {4{`SWK_EN_RST}};
      dif.clr <= 4'h0;
    end else if (CLK_EN) begin
      aw_have_q <= aw_have_d;
      aw_addr_q <= aw_addr_d;
      w_have_q <= w_have_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      sel_q <= sel_d;
      en_q <= en_d;
      dif.clr <= clr_d;
    end
  end

  assign dif.sel = sel_q;
  assign dif.en = en_q;
  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RDATA = rdata_q;
  assign S_AXI_RRESP = rresp_q;
  assign WAKE_REQ = dif.req;

  // The detectors see the raw pins; synchronisation happens inside.
  swk_detect u_detect (
    .clk(SYS_CLK),
    .rst_b(RST_B),
    .ce(CLK_EN),
    .pin(EXT_INT),
    .dif(dif)
  );
endmodule : swk_top

// [tb/swk_top_sva.sv]
// Checker of bus handshakes, reset state and request clearing of the wake source block.
`timescale 1ns/1ps
module swk_top_sva (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic [3:0] WAKE_REQ,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);
  // Right after reset no request or answer may be left over.
  a_reset_clean: assert property ($rose(RST_B) |-> !S_AXI_BVALID && !S_AXI_RVALID && WAKE_REQ == 4'h0)
    else $error("state not clean after reset");
  a_read_latency: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read answer late");
  a_read_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID)
    else $error("read answer dropped");
  a_read_block: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read taken while answer pending");
  a_write_latency: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
    |=> !S_AXI_BVALID ##1 S_AXI_BVALID)
    else $error("write answer timing wrong");
  a_resp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
    else $error("write answer dropped");
  a_write_block: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write taken while answer pending");
  // A request only falls one to three cycles after a write answer.
  a_req_clear: assert property (($past(WAKE_REQ) & ~WAKE_REQ) != 4'h0
    |-> $past(S_AXI_BVALID, 1) || $past(S_AXI_BVALID, 2) || $past(S_AXI_BVALID, 3))
    else $error("request fell without a clear");
endmodule : swk_top_sva
bind swk_top swk_top_sva i_sva (.*);

// [tb/swk_pin_model.sv]
// Model of the four external wake pins that face the block.
`timescale 1ns/1ps
module swk_pin_model (
  input wire logic clk,
  output logic [3:0] pins
);
  // Pins start low and hold each level until the next call, so no pulse is shorter than one cycle.
  initial pins = 4'h0;
  task automatic drive(input logic [3:0] v);
    @(posedge clk);
    pins <= v;
  endtask : drive
endmodule : swk_pin_model

// [tb/standby_wake_source_config_tb.sv]
// Self-checking bench of the wake source block over its register bus and pins.
`timescale 1ns/1ps
`include "swk_defines.svh"
module standby_wake_source_config_tb;
  logic SYS_CLK, RST_B, CLK_EN, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID;
  logic S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
  logic [3:0] EXT_INT, WAKE_REQ, S_AXI_WSTRB;
  logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  int num_errors = 0;
  int samples_checked = 0;
  // Rows: selector code, start pin, end pin, enable, expected request, expected seen edge.
  logic [11:0] tab [8] = '{12'h0b0, 12'h170, 12'h2b0, 12'h370, 12'h3a0, 12'h471, 12'h4b2, 12'h140};
  swk_top i_dut (.*);
  swk_pin_model i_pins (.clk(SYS_CLK), .pins(EXT_INT));
  initial begin
    SYS_CLK = 1'b0;
    forever #10 SYS_CLK = ~SYS_CLK;
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // Ready and valid are sampled mid-cycle, where the comb readies are settled.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w, b;
    @(posedge SYS_CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    do begin
      @(negedge SYS_CLK);
      aw = S_AXI_AWREADY;
      w = S_AXI_WREADY;
      b = S_AXI_BVALID;
      r = S_AXI_BRESP;
      @(posedge SYS_CLK);
      if (aw) S_AXI_AWVALID <= 1'b0;
      if (w) S_AXI_WVALID <= 1'b0;
    end while (!b);
    S_AXI_BREADY <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, v;
    @(posedge SYS_CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do begin
      @(negedge SYS_CLK);
      ar = S_AXI_ARREADY;
      v = S_AXI_RVALID;
      d = S_AXI_RDATA;
      r = S_AXI_RRESP;
      @(posedge SYS_CLK);
      if (ar) S_AXI_ARVALID <= 1'b0;
    end while (!v);
    S_AXI_RREADY <= 1'b0;
  endtask : rd
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  // A hung handshake ends the run as a failure.
  initial begin
    repeat (20000) @(posedge SYS_CLK);
    num_errors++;
    finish_test();
  end
  // Main sequence; only selector codes 000 to 100 are ever written, selector before enable.
  initial begin
    int i;
    logic [31:0] d, s;
    logic [1:0] r;
    logic [11:0] e;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 5'h00;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = 48'h0;
    S_AXI_WSTRB = 4'hf;
    CLK_EN = 1'b1;
    RST_B = 1'b0;
    repeat (6) @(posedge SYS_CLK);
    RST_B <= 1'b1;
    rd(`SWK_OFS_MODE, d, r);
    chk("mode reset", d, 32'h20202020);
    wr(`SWK_OFS_MODE, 32'h0e4e3e9e, r);
    chk("write resp", 32'(r), 32'(`SWK_RESP_OKAY));
    rd(`SWK_OFS_MODE, d, r);
    chk("layout", d, 32'h00403010);
    wr(`SWK_OFS_STATUS, 32'h0000000f, r);
    chk("status write", 32'(r), 32'(`SWK_RESP_SLVERR));
    rd(8'hfc, d, r);
    chk("unmapped", {d[29:0], r}, 32'(`SWK_RESP_SLVERR));
    rd(`SWK_OFS_CLEAR, d, r);
    chk("clear read", {d[29:0], r}, 32'(`SWK_RESP_OKAY));
    for (int k = 0; k < 8; k++) begin
      e = tab[k];
      i = k % 4;
      s = 32'(e[10:8]) << (8 * i + 4);
      i_pins.drive({3'h0, e[7]} << i);
      wr(`SWK_OFS_MODE, s, r);
      wr(`SWK_OFS_CLEAR, 32'h0000000f, r);
      wr(`SWK_OFS_MODE, s | (32'(e[5]) << (8 * i)), r);
      i_pins.drive({3'h0, e[6]} << i);
      // Looked at between edges, so the request flop is settled when it is compared.
      repeat (4) @(negedge SYS_CLK);
      chk("wake", 32'(WAKE_REQ), 32'(e[4]) << i);
      rd(`SWK_OFS_MODE, d, r);
      chk("seen", 32'(d[8 * i + 2 +: 2]), 32'(e[1:0]));
      rd(`SWK_OFS_STATUS, d, r);
      chk("status", d, 32'(e[4]) << i);
      wr(`SWK_OFS_MODE, s, r);
      i_pins.drive({3'h0, e[7]} << i);
      wr(`SWK_OFS_CLEAR, 32'h1 << i, r);
      repeat (4) @(negedge SYS_CLK);
      chk("cleared", 32'(WAKE_REQ), 32'h0);
      rd(`SWK_OFS_MODE, d, r);
      chk("seen cleared", d, s);
    end
    // Only byte lane 1 is written, so source 1 alone moves to both edges and the rest keep their fields.
    S_AXI_WSTRB <= 4'h2;
    wr(`SWK_OFS_MODE, 32'h40404040, r);
    S_AXI_WSTRB <= 4'hf;
    rd(`SWK_OFS_MODE, d, r);
    chk("lane write", d, 32'h10004000);
    wr(`SWK_OFS_MODE, 32'h10004100, r);
    // A rising pin while the clock enable is low must not move the detectors until it returns.
    CLK_EN <= 1'b0;
    i_pins.drive(4'h2);
    repeat (6) @(negedge SYS_CLK);
    chk("frozen", 32'(WAKE_REQ), 32'h0);
    @(posedge SYS_CLK);
    CLK_EN <= 1'b1;
    repeat (4) @(negedge SYS_CLK);
    chk("thawed", 32'(WAKE_REQ), 32'h2);
    rd(`SWK_OFS_MODE, d, r);
    chk("both rise", d, 32'h10004500);
    finish_test();
  end
endmodule : standby_wake_source_config_tb
